// file: hdl/prd_regs.svh
// constants of the parameter-read responder and diagnostic record
`ifndef PRD_REGS_SVH
`define PRD_REGS_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PRD_CLK_PERIOD_NS 50
`define PRD_US_NS         1000
`define PRD_TICKS_PER_US  (`PRD_US_NS / `PRD_CLK_PERIOD_NS)
// ----------------------------------------------------------------
// telegram fields
// ----------------------------------------------------------------
`define PRD_TYPE_READ   3'h6
`define PRD_TYPE_CMD    3'h4
`define PRD_CMD_CLR     8'h03
`define PRD_IDX_STATUS  8'h29
`define PRD_LEN_STATUS  4'h4
`define PRD_LEN_PARAM   4'h0
`define PRD_COMM_OK     4'h0
`define PRD_COMMON_OK   8'h00
// ----------------------------------------------------------------
// diagnostic record layout and reset values
// ----------------------------------------------------------------
`define PRD_MODCLASS_RST  8'h15
`define PRD_CHKIND_RST    8'h71
`define PRD_DIAGBITS_RST  8'h08
`define PRD_CHCOUNT_RST   8'h03
`define PRD_POS_SUMMARY   0
`define PRD_POS_MODCLASS  1
`define PRD_POS_RSVD      2
`define PRD_POS_INTERNAL  3
`define PRD_POS_CHKIND    4
`define PRD_POS_DIAGBITS  5
`define PRD_POS_CHCOUNT   6
`define PRD_POS_CHMAP     7
`define PRD_POS_CH0       8
`define PRD_POS_STAMP     5'h10
`define PRD_REC_LEN       5'h14
`define PRD_REC_HEAD_LEN  5'h04
`define PRD_STAMP_LEN     5'h04
`define PRD_SET_FULL      16'h0001
`define PRD_SET_HEAD      16'h0000
`define PRD_OBJ_FULL      16'h2F01
`define PRD_OBJ_HEAD      16'h2F00
`define PRD_SX_FIRST      8'h02
`define PRD_SX_LAST_BYTE  8'h11
`define PRD_SX_STAMP      8'h13
`endif

// file: hdl/prd_pkg.sv
// types of the parameter-read responder and diagnostic record
package prd_pkg;
  // ----------------------------------------------------------------
  // telegram carrier: b0 first, d[0] is user byte D00
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       b0;
    logic [7:0]       b1;
    logic [7:0]       b2;
    logic [7:0]       b3;
    logic [0:11][7:0] d;
  } prd_frame_t;

  // record access path
  typedef enum logic [1:0] {
    PRD_REC_SET = 2'h0,
    PRD_REC_OBJ = 2'h1,
    PRD_REC_SUB = 2'h2
  } prd_rec_kind_t;

  // decoded window into the record
  typedef struct packed {
    logic       ok;
    logic [4:0] start;
    logic [4:0] len;
  } prd_map_t;

  typedef enum logic [1:0] {
    PRD_IDLE  = 2'b01,
    PRD_FETCH = 2'b10
  } prd_fsm_t;

  // whole state of the responder
  typedef struct packed {
    prd_fsm_t   fsm;
    logic [38:0] s1;
    logic [38:0] s2;
    logic [38:0] s3;
    logic [38:0] filt;
    logic [31:0] status;
    logic [31:0] snap;
    logic [3:0]  last_tag;
    logic        tag_seen;
    logic [7:0]  param_idx;
    logic        resp_valid;
    prd_frame_t  resp;
    logic [2:0]  led;
    logic [31:0] stamp;
    logic        rec_ack;
    logic        rec_ok;
    logic [4:0]  rec_len;
    logic [159:0] rec_data;
  } prd_state_t;

  // whole state of the microsecond ticker
  typedef struct packed {
    logic [4:0]  div;
    logic        tick;
    logic [31:0] count;
  } prd_tick_state_t;
endpackage : prd_pkg

// file: hdl/prd_us_ticker.sv
// free-running microsecond counter
`timescale 1ns/1ps
`include "prd_regs.svh"
module prd_us_ticker (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // time base
  output logic [31:0]      us_count
);
  localparam logic [4:0] DIV_LAST = 5'(`PRD_TICKS_PER_US - 1);

  prd_pkg::prd_tick_state_t r;
  prd_pkg::prd_tick_state_t n;

  // ----------------------------------------------------------------
  // divider gives a one-cycle tick each microsecond
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.tick = (r.div == DIV_LAST);
    n.div = n.tick ? 5'h00 : 5'(r.div + 5'h01);
    if (r.tick) begin
      n.count = r.count + 32'h00000001; // wraps to zero at the top
    end
  end

  // state register, zero at power-up
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign us_count = r.count;

  count_step_a: assert property (
    @(posedge core_clk) disable iff (rst)
    r.tick |=> r.count == $past(r.count) + 32'h00000001 ##1 $stable(r.count)
  ) else $error("ticker did not advance by one");
endmodule : prd_us_ticker

// file: hdl/prd_param_diag.sv
// parameter-read responder with diagnostic record
// Behaviour
// - read requests carry type 110 in bits 6..4
// - response echoes requested parameter index
// - length zero; dataset tag echoed, one-time read
// - common status and user data ignored
// - response byte 0: type 110, comm status
// - response: common status, parameter value bytes
// - index 41 returns sticky limit status bits
// - command 0x03 clears masked bits, echoes request
// - still-present conditions set bits again
// - no diagnostic interrupt, record only
// - errors drive channel indicator and record
// - record set 01h full, 00h first four
// - object 2F01h full, 2F00h first four
// - subindex fields under 5005h, 02h..11h and 13h
// - constant bits per channel and channel count
// - channel bytes 0..2, five reserved zeros
// - summary byte error flag layout
// - parametrization errors detected and recorded
// - free microsecond counter, wraps at 32 bits
// - diagnostic event captures microsecond timestamp
// - channel map bit n per channel error
// - channel byte bit 0 parametrization error
`timescale 1ns/1ps
`include "prd_regs.svh"
module prd_param_diag (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // process image request
  input  wire logic                 req_valid,
  input  wire prd_pkg::prd_frame_t  req_frame,
  // process image response
  output logic                      resp_valid,
  output prd_pkg::prd_frame_t       resp_frame,
  // parameter store lookup
  output logic [7:0]                param_rd_index,
  input  wire logic [95:0]          param_rd_data,
  // condition pins
  input  wire logic [31:0]          limit_cond,
  input  wire logic                 module_fail,
  input  wire logic                 internal_err,
  input  wire logic                 external_err,
  input  wire logic                 aux_supply_missing,
  input  wire logic [2:0]           chan_param_err,
  // channel error indicators
  output logic [2:0]                chan_err_led,
  // diagnostic record access
  input  wire logic                 rec_req,
  input  wire prd_pkg::prd_rec_kind_t rec_kind,
  input  wire logic [15:0]          rec_key,
  output logic                      rec_ack,
  output logic                      rec_ok,
  output logic [4:0]                rec_len,
  output logic [159:0]              rec_data
);
  prd_pkg::prd_state_t r;
  prd_pkg::prd_state_t n;
  logic [19:0][7:0]    rec;
  logic [31:0]         us_count;
  logic [31:0]         clr_mask;
  logic [31:0]         stat_val;
  logic                fresh;
  logic [2:0]          chan_err;
  logic [6:0]          diag_rise;
  prd_pkg::prd_map_t   m;

  // ----------------------------------------------------------------
  // microsecond time base
  // ----------------------------------------------------------------
  prd_us_ticker u_ticker (
    .core_clk (core_clk),
    .rst      (rst),
    .us_count (us_count)
  );

  // ----------------------------------------------------------------
  // record window decode
  // ----------------------------------------------------------------
  function automatic prd_pkg::prd_map_t rec_map(
    input prd_pkg::prd_rec_kind_t kind,
    input logic [15:0]            key
  );
    prd_pkg::prd_map_t mp;
    mp = '0;
    case (kind)
      prd_pkg::PRD_REC_SET: begin
        if (key == `PRD_SET_FULL) begin
          mp = '{1'b1, 5'h00, `PRD_REC_LEN};
        end else if (key == `PRD_SET_HEAD) begin
          mp = '{1'b1, 5'h00, `PRD_REC_HEAD_LEN};
        end
      end
      prd_pkg::PRD_REC_OBJ: begin
        if (key == `PRD_OBJ_FULL) begin
          mp = '{1'b1, 5'h00, `PRD_REC_LEN};
        end else if (key == `PRD_OBJ_HEAD) begin
          mp = '{1'b1, 5'h00, `PRD_REC_HEAD_LEN};
        end
      end
      prd_pkg::PRD_REC_SUB: begin
        if (key[15:8] == 8'h00 && key[7:0] >= `PRD_SX_FIRST
            && key[7:0] <= `PRD_SX_LAST_BYTE) begin
          mp = '{1'b1, 5'(key[7:0] - `PRD_SX_FIRST), 5'h01};
        end else if (key == {8'h00, `PRD_SX_STAMP}) begin
          mp = '{1'b1, `PRD_POS_STAMP, `PRD_STAMP_LEN};
        end
      end
      default: begin
        mp = '0;
      end
    endcase
    return mp;
  endfunction : rec_map

  // ----------------------------------------------------------------
  // diagnostic record contents, byte 0 first
  // ----------------------------------------------------------------
  assign chan_err = r.filt[38:36];
  // summary: fail, internal, external, channel, aux, param at bit 7
  assign rec[`PRD_POS_SUMMARY] = {|chan_err, 2'b00, r.filt[35],
                                  |chan_err, r.filt[34:32]};
  assign rec[`PRD_POS_MODCLASS] = `PRD_MODCLASS_RST;
  assign rec[`PRD_POS_RSVD]     = 8'h00;
  assign rec[`PRD_POS_INTERNAL] = 8'h00;
  assign rec[`PRD_POS_CHKIND]   = `PRD_CHKIND_RST;
  assign rec[`PRD_POS_DIAGBITS] = `PRD_DIAGBITS_RST;
  assign rec[`PRD_POS_CHCOUNT]  = `PRD_CHCOUNT_RST;
  assign rec[`PRD_POS_CHMAP]    = {5'h00, chan_err};

  // per-channel error bytes then the reserved ones
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_chan
      if (gi < 3) begin : g_live
        assign rec[`PRD_POS_CH0 + gi] = {7'h00, chan_err[gi]};
      end else begin : g_rsvd
        assign rec[`PRD_POS_CH0 + gi] = 8'h00;
      end
    end
    for (gi = 0; gi < 4; gi++) begin : g_stamp
      assign rec[16 + gi] = r.stamp[gi*8 +: 8];
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    clr_mask = 32'h00000000;
    stat_val = r.snap;
    fresh = 1'b0;
    m = '0;
    n.resp_valid = 1'b0;
    n.rec_ack = 1'b0;
    // three-stage pin sync, a change counts once stages 2 and 3 agree
    n.s1 = {chan_param_err, aux_supply_missing, external_err,
            internal_err, module_fail, limit_cond};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.filt = (r.s3 & ~(r.s2 ^ r.s3)) | (r.filt & (r.s2 ^ r.s3));
    // telegram decode
    case (r.fsm)
      prd_pkg::PRD_IDLE: begin
        // only bits 6..4 of byte 0 select the type; byte 3 and data unread
        if (req_valid && req_frame.b0[6:4] == `PRD_TYPE_READ) begin
          n.resp.b0 = {1'b0, `PRD_TYPE_READ, `PRD_COMM_OK};
          n.resp.b1 = req_frame.b1;
          n.resp.b3 = `PRD_COMMON_OK;
          if (req_frame.b1 == `PRD_IDX_STATUS) begin
            // a new dataset tag takes a fresh copy, a repeated one re-reads it
            fresh = !r.tag_seen || (req_frame.b2[3:0] != r.last_tag);
            stat_val = fresh ? r.status : r.snap;
            n.snap = stat_val;
            n.tag_seen = 1'b1;
            n.last_tag = req_frame.b2[3:0];
            n.resp.b2 = {`PRD_LEN_STATUS, req_frame.b2[3:0]};
            n.resp.d = {stat_val, 64'h0};
            n.resp_valid = 1'b1;
          end else begin
            n.param_idx = req_frame.b1;
            n.resp.b2 = {`PRD_LEN_PARAM, req_frame.b2[3:0]};
            n.fsm = prd_pkg::PRD_FETCH;
          end
        end else if (req_valid && req_frame.b0[6:4] == `PRD_TYPE_CMD) begin
          n.resp = req_frame;
          n.resp.b3 = `PRD_COMMON_OK;
          n.resp_valid = 1'b1;
          if (req_frame.b1 == `PRD_CMD_CLR) begin
            clr_mask = {req_frame.d[0], req_frame.d[1],
                        req_frame.d[2], req_frame.d[3]};
          end
        end
      end
      prd_pkg::PRD_FETCH: begin
        n.resp.d = param_rd_data;
        n.resp_valid = 1'b1;
        n.fsm = prd_pkg::PRD_IDLE;
      end
      default: begin
        n.fsm = prd_pkg::PRD_IDLE;
      end
    endcase
    // sticky limit bits: a present condition beats the clear
    n.status = (r.status & ~clr_mask) | r.filt[31:0];
    // indicators follow channel errors
    n.led = chan_err;
    // timestamp any newly raised diagnostic condition
    diag_rise = n.filt[38:32] & ~r.filt[38:32];
    if (|diag_rise) begin
      n.stamp = us_count;
    end
    // record reads answer in the next cycle
    if (rec_req) begin
      m = rec_map(rec_kind, rec_key);
      n.rec_ack = 1'b1;
      n.rec_ok = m.ok;
      n.rec_len = m.ok ? m.len : 5'h00;
      n.rec_data = '0;
      for (int i = 0; i < 20; i++) begin
        if (m.ok && 5'(i) < m.len) begin
          n.rec_data[i*8 +: 8] = rec[5'(m.start + 5'(i))];
        end
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.fsm <= prd_pkg::PRD_IDLE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops; no interrupt output exists
  // ----------------------------------------------------------------
  assign resp_valid     = r.resp_valid;
  assign resp_frame     = r.resp;
  assign param_rd_index = r.param_idx;
  assign chan_err_led   = r.led;
  assign rec_ack        = r.rec_ack;
  assign rec_ok         = r.rec_ok;
  assign rec_len        = r.rec_len;
  assign rec_data       = r.rec_data;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence read_other_s;
    r.fsm == prd_pkg::PRD_IDLE && req_valid
    && req_frame.b0[6:4] == `PRD_TYPE_READ && req_frame.b1 != `PRD_IDX_STATUS;
  endsequence

  sequence fetch_answer_s;
    r.fsm == prd_pkg::PRD_FETCH && !resp_valid ##1 resp_valid
    && resp_frame.d == $past(param_rd_data);
  endsequence

  read_echo_a: assert property (
    r.fsm == prd_pkg::PRD_IDLE && req_valid
    && req_frame.b0[6:4] == `PRD_TYPE_READ
    |=> ##[0:1] resp_valid && resp_frame.b0[6:0] == 7'h60
  ) else $error("read response header wrong");

  index_hold_a: assert property (
    read_other_s |=> resp_frame.b1 == $past(req_frame.b1)
    && param_rd_index == $past(req_frame.b1)
  ) else $error("parameter index not echoed");

  fetch_path_a: assert property (
    read_other_s |=> fetch_answer_s
  ) else $error("parameter value not returned");

  other_type_a: assert property (
    r.fsm == prd_pkg::PRD_IDLE && req_valid
    && req_frame.b0[6:4] != `PRD_TYPE_READ && req_frame.b0[6:4] != `PRD_TYPE_CMD
    |=> !resp_valid
  ) else $error("unknown telegram answered");

  clear_echo_a: assert property (
    r.fsm == prd_pkg::PRD_IDLE && req_valid
    && req_frame.b0[6:4] == `PRD_TYPE_CMD
    |=> resp_valid && resp_frame.d == $past(req_frame.d)
    && resp_frame.b1 == $past(req_frame.b1)
  ) else $error("command not echoed");

  status_set_a: assert property (
    ##1 (r.status & $past(r.filt[31:0])) == $past(r.filt[31:0])
  ) else $error("present condition lost from status");

  led_follow_a: assert property (
    $changed(r.filt[38:36]) |=> chan_err_led == $past(r.filt[38:36])
  ) else $error("channel indicator wrong");

  set_full_a: assert property (
    rec_req && rec_kind == prd_pkg::PRD_REC_SET && rec_key == `PRD_SET_FULL
    |=> rec_ack && rec_ok && rec_len == 5'h14
    && rec_data[55:48] == 8'h03 && rec_data[47:40] == 8'h08
  ) else $error("full record wrong");

  obj_head_a: assert property (
    rec_req && rec_kind == prd_pkg::PRD_REC_OBJ && rec_key == `PRD_OBJ_HEAD
    |=> rec_ok && rec_len == 5'h04 && rec_data[159:32] == '0
  ) else $error("record head wrong");

  stamp_read_a: assert property (
    rec_req && rec_kind == prd_pkg::PRD_REC_SUB && rec_key == 16'h0013
    |=> rec_len == 5'h04 && rec_data[31:0] == $past(r.stamp)
  ) else $error("timestamp field wrong");

  rsvd_zero_a: assert property (
    rec_req && rec_kind == prd_pkg::PRD_REC_SUB && rec_key == 16'h000D
    |=> rec_ok && rec_len == 5'h01 && rec_data == '0
  ) else $error("reserved byte not zero");
endmodule : prd_param_diag

// file: testbench/prd_param_store.sv
// parameter store model standing behind the responder's lookup port
`timescale 1ns/1ps
module prd_param_store (
  // lookup from the responder
  input  wire logic [7:0]  param_rd_index,
  output logic [95:0]      param_rd_data
);
  // ----------------------------------------------------------------
  // value pattern per index
  // ----------------------------------------------------------------
  // answers at once, so the fetch cycle always sees a settled value
  assign param_rd_data = {4{param_rd_index, ~param_rd_index, param_rd_index ^ 8'h5A}};
endmodule : prd_param_store

// file: testbench/tb_param_read_and_diag_record.sv
// self-checking bench of the parameter-read responder and diagnostic record
`timescale 1ns/1ps
module tb_param_read_and_diag_record;
  // ----------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------
  logic                   core_clk;
  logic                   rst;
  logic                   req_valid;
  prd_pkg::prd_frame_t    req_frame;
  logic                   resp_valid;
  prd_pkg::prd_frame_t    resp_frame;
  logic [7:0]             param_rd_index;
  logic [95:0]            param_rd_data;
  logic [31:0]            limit_cond;
  logic [3:0]             pins;  // aux, ext, int, fail
  logic [2:0]             chan_param_err;
  logic [2:0]             chan_err_led;
  logic                   rec_req;
  prd_pkg::prd_rec_kind_t rec_kind;
  logic [15:0]            rec_key;
  logic                   rec_ack;
  logic                   rec_ok;
  logic [4:0]             rec_len;
  logic [159:0]           rec_data;
  prd_pkg::prd_frame_t    got;
  logic [31:0]            ts_lo;
  logic [31:0]            ts_hi;
  int                     error_cnt = 0;
  int                     samples_checked = 0;
  int                     cyc = 0;
  int                     rel = 0;
  int                     seed;
  localparam logic [165:0] full_m = {6'h3F, 32'h0, {128{1'b1}}};

  // clock of 50 ns
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // cycle count and hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // design and partner
  // ----------------------------------------------------------------
  prd_param_diag i_dut (
    .core_clk           (core_clk),
    .rst                (rst),
    .req_valid          (req_valid),
    .req_frame          (req_frame),
    .resp_valid         (resp_valid),
    .resp_frame         (resp_frame),
    .param_rd_index     (param_rd_index),
    .param_rd_data      (param_rd_data),
    .limit_cond         (limit_cond),
    .module_fail        (pins[0]),
    .internal_err       (pins[1]),
    .external_err       (pins[2]),
    .aux_supply_missing (pins[3]),
    .chan_param_err     (chan_param_err),
    .chan_err_led       (chan_err_led),
    .rec_req            (rec_req),
    .rec_kind           (rec_kind),
    .rec_key            (rec_key),
    .rec_ack            (rec_ack),
    .rec_ok             (rec_ok),
    .rec_len            (rec_len),
    .rec_data           (rec_data)
  );

  prd_param_store i_store (
    .param_rd_index (param_rd_index),
    .param_rd_data  (param_rd_data)
  );

  // ----------------------------------------------------------------
  // comparisons and verdict
  // ----------------------------------------------------------------
  task automatic bad(input logic [165:0] e, input logic [165:0] a);
    error_cnt++;
    $display("mismatch at %0t: expected %h got %h", $time, e, a);
  endtask : bad

  task automatic chk_frame(input prd_pkg::prd_frame_t e, input prd_pkg::prd_frame_t a);
    samples_checked++;
    if (a !== e) bad(e, a);
  endtask : chk_frame

  task automatic chk_word(input logic [31:0] e, input logic [31:0] a);
    samples_checked++;
    if (a !== e) bad(e, a);
  endtask : chk_word

  // timestamp must lie in the window around the event
  task automatic chk_stamp(input logic [31:0] a);
    samples_checked++;
    if ((a >= ts_lo && a <= ts_hi) !== 1'b1) bad(ts_lo, a);
  endtask : chk_stamp

  task automatic chk_rec(input logic [165:0] e, input logic [165:0] m);
    samples_checked++;
    if (({rec_ok, rec_len, rec_data} & m) !== (e & m)) bad(e, {rec_ok, rec_len, rec_data});
  endtask : chk_rec

  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // expectations and stimulus helpers
  // ----------------------------------------------------------------
  function automatic prd_pkg::prd_frame_t exp_read(input logic [7:0] idx, input logic [3:0] tag,
                                                   input logic [31:0] st);
    prd_pkg::prd_frame_t e;
    e = '0;
    e.b0 = 8'h60;
    e.b1 = idx;
    e.b2 = {(idx == 8'h29) ? 4'h4 : 4'h0, tag};
    if (idx == 8'h29) e.d[0:3] = st;
    else e.d = {4{idx, ~idx, idx ^ 8'h5A}};
    return e;
  endfunction : exp_read

  // record bytes 15..0, byte 0 lowest
  function automatic logic [127:0] exp_rec(input logic [3:0] p, input logic [2:0] c);
    logic [7:0] s;
    s = {|c, 2'b00, p[3], |c, p[2:0]};
    return {40'h0, 7'h0, c[2], 7'h0, c[1], 7'h0, c[0], 5'h0, c, 32'h03087100, 16'h0015, s};
  endfunction : exp_rec

  // random filler in common status and user data
  function automatic prd_pkg::prd_frame_t mk(input logic [7:0] b0, b1, b2);
    prd_pkg::prd_frame_t f;
    f = {$random(seed), $random(seed), $random(seed), $random(seed)};
    f.b0 = b0;
    f.b1 = b1;
    f.b2 = b2;
    return f;
  endfunction : mk

  // read request with random noise in the ignored bits of byte 0
  function automatic prd_pkg::prd_frame_t mk_rd(input logic [7:0] idx, input logic [3:0] tag);
    return mk(8'h60 | (8'($random(seed)) & 8'h8F), idx, {4'h0, tag});
  endfunction : mk_rd

  task automatic send(input prd_pkg::prd_frame_t f, input logic ea);
    int n;
    req_frame = f;
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 4) begin
      @(negedge core_clk);
      n++;
    end
    chk_word({31'h0, ea}, {31'h0, resp_valid});
    got = resp_frame;
    repeat (2) @(negedge core_clk);
  endtask : send

  task automatic rec_do(input prd_pkg::prd_rec_kind_t k, input logic [15:0] key,
                        input logic [165:0] e, input logic [165:0] m);
    int n;
    rec_kind = k;
    rec_key = key;
    rec_req = 1'b1;
    @(negedge core_clk);
    rec_req = 1'b0;
    n = 0;
    while (rec_ack !== 1'b1 && n < 4) begin
      @(negedge core_clk);
      n++;
    end
    chk_word(32'h1, {31'h0, rec_ack});
    chk_rec(e, m);
  endtask : rec_do

  // raise conditions from quiet and read the record every way
  task automatic diag_round(input logic [3:0] p, input logic [2:0] c);
    logic [127:0] r;
    int k;
    pins = 4'h0;
    chan_param_err = 3'h0;
    repeat (8) @(negedge core_clk);
    ts_lo = (cyc - rel >= 20) ? (cyc - rel) / 20 - 1 : 0;
    pins = p;
    chan_param_err = c;
    repeat (8) @(negedge core_clk);
    ts_hi = (cyc - rel) / 20 + 1;
    r = exp_rec(p, c);
    chk_word({29'h0, c}, {29'h0, chan_err_led});
    rec_do(prd_pkg::PRD_REC_SET, 16'h0001, {1'b1, 5'd20, 32'h0, r}, full_m);
    chk_stamp(rec_data[159:128]);
    rec_do(prd_pkg::PRD_REC_OBJ, 16'h2F01, {1'b1, 5'd20, 32'h0, r}, full_m);
    chk_stamp(rec_data[159:128]);
    rec_do(prd_pkg::PRD_REC_SET, 16'h0000, {1'b1, 5'd4, 128'h0, r[31:0]}, '1);
    rec_do(prd_pkg::PRD_REC_OBJ, 16'h2F00, {1'b1, 5'd4, 128'h0, r[31:0]}, '1);
    for (k = 2; k <= 17; k++) begin
      rec_do(prd_pkg::PRD_REC_SUB, 16'(k), {1'b1, 5'd1, 152'h0, r[8*(k-2) +: 8]}, '1);
    end
    rec_do(prd_pkg::PRD_REC_SUB, 16'h0013, {6'h24, 160'h0}, {6'h3F, {128{1'b1}}, 32'h0});
    chk_stamp(rec_data[31:0]);
    rec_do(prd_pkg::PRD_REC_SUB, 16'h0012, 166'h0, '1);
    rec_do(prd_pkg::PRD_REC_SET, 16'h0002, 166'h0, '1);
    rec_do(prd_pkg::PRD_REC_OBJ, 16'h2F02, 166'h0, '1);
  endtask : diag_round

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0]         sticky;
    logic [31:0]         m;
    logic [3:0]          tag;
    logic [7:0]          idx;
    logic [2:0]          ot [6];
    prd_pkg::prd_frame_t f;
    prd_pkg::prd_frame_t e;
    int                  i;
    ot = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
    seed = 32'he7f7b86f;
    rst = 1'b1;
    req_valid = 1'b0;
    req_frame = '0;
    limit_cond = 32'h0;
    pins = 4'h0;
    chan_param_err = 3'h0;
    rec_req = 1'b0;
    rec_kind = prd_pkg::PRD_REC_SET;
    rec_key = 16'h0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    rel = cyc;
    // quiet record after reset
    ts_lo = 32'h0;
    ts_hi = 32'h0;
    rec_do(prd_pkg::PRD_REC_SET, 16'h0001, {6'h34, 32'h0, exp_rec(4'h0, 3'h0)}, '1);
    chk_word(32'h0, {29'h0, chan_err_led});
    // diagnostic conditions
    for (i = 0; i < 3; i++) begin
      f[6:0] = 7'($random(seed));
      if (f[6:0] == 7'h0) f[6:0] = 7'h41;
      diag_round(f[3:0], f[6:4]);
    end
    // other parameter reads, then telegram types without an answer
    for (i = 0; i < 10; i++) begin
      idx = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      if (idx == 8'h29) idx = 8'h2A;
      tag = 4'($random(seed));
      send(mk_rd(idx, tag), 1'b1);
      chk_frame(exp_read(idx, tag, 32'h0), got);
      chk_word({24'h0, idx}, {24'h0, param_rd_index});
    end
    foreach (ot[j]) begin
      send(mk({1'b0, ot[j], 4'h0}, 8'h29, 8'h01), 1'b0);
    end
    // limit status: sticky bits, one-time read, clearing
    sticky = 32'h0;
    tag = 4'h0;
    for (i = 0; i < 6; i++) begin
      limit_cond = $random(seed);
      repeat (6) @(negedge core_clk);
      sticky = sticky | limit_cond;
      tag = tag + 4'h1;
      f = mk_rd(8'h29, tag);
      send(f, 1'b1);
      chk_frame(exp_read(8'h29, tag, sticky), got);
      limit_cond = $random(seed);
      repeat (6) @(negedge core_clk);
      send(f, 1'b1);
      chk_frame(exp_read(8'h29, tag, sticky), got);
      sticky = sticky | limit_cond;
      m = (i == 5) ? 32'hFFFFFFFF : $random(seed);
      f = mk(8'h40, i[0] ? 8'h01 : 8'h03, 8'h45);
      f.d[0:3] = m;
      send(f, 1'b1);
      e = f;
      e.b3 = 8'h00;
      chk_frame(e, got);
      if (!i[0]) sticky = (sticky & ~m) | limit_cond;
    end
    // ended conditions stay cleared
    limit_cond = 32'h0;
    repeat (6) @(negedge core_clk);
    send(mk(8'h40, 8'h03, 8'h45) | 128'hFFFFFFFF << 64, 1'b1);
    tag = tag + 4'h1;
    send(mk_rd(8'h29, tag), 1'b1);
    chk_frame(exp_read(8'h29, tag, 32'h0), got);
    complete_run();
  end
endmodule : tb_param_read_and_diag_record
